// file: rtl/sbsi_top.sv
// Top level of the system bus signal interface.
// Operation
// RULE1: After reset two external lines feed interrupt one and two feed interrupt seven; the code ORs the alt_route bit itself into each, so both read set.
// RULE2: The integrator picks one line per interrupt and moves duplicates to alternate use.
// RULE3: Eight internal interrupt requests reach the core, each fed by its selected pins.
// RULE4: In external master mode the address pins carry internal masters' addresses or are sampled.
// RULE5: In internal master mode the address pins carry the memory controller's address.
// RULE6: The bus master drives the transfer kind code through the whole address tenure.
// RULE7: The bus master drives the transfer byte count code during the tenure.
// RULE8: The burst flag is asserted exactly when the transaction is a four quad word burst.
// RULE9: On-chip masters drive the global flag; set means caches must snoop the transfer.
// RULE10: Five burst address outputs exist; bits 29 to 31 share pins with interrupts 2, 3, 5.
// RULE11: Shared pins offer only burst address output or interrupt input, never a primary use.
// RULE12: A per-pin selection, reset to interrupt input, picks the shared pin function.
`timescale 1ns/1ns
module sbsi_top
  import sbsi_pkg::*;
(
  // Clock and reset.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  // Mode and configuration.
  input wire logic EXT_MASTER_MODE,
  input wire logic [SHARED_N-1:0] PIN_SEL_WR_DATA,
  input wire logic PIN_SEL_WR,
  input wire logic [IRQ_N-1:0] ALT_ROUTE_WR_DATA,
  input wire logic ALT_ROUTE_WR,
  output logic [SHARED_N-1:0] PIN_SEL,
  // Internal master request side.
  input wire logic INT_START,
  input wire logic [ADDR_W-1:0] INT_ADDR,
  input wire logic [KIND_W-1:0] INT_KIND,
  input wire logic [SIZE_W-1:0] INT_SIZE,
  input wire logic INT_BURST,
  input wire logic INT_GLOBAL,
  input wire logic ADDR_ACK,
  output logic INT_BUSY,
  // Memory controller side.
  input wire logic [ADDR_W-1:0] MC_ADDR,
  input wire logic [BADDR_W-1:0] MC_BADDR,
  // Address pins.
  input wire logic [ADDR_W-1:0] ADDR_I,
  output logic [ADDR_W-1:0] ADDR_O,
  output logic ADDR_OE_N,
  // Transfer qualifier pins.
  input wire logic [KIND_W-1:0] TRANSFER_KIND_CODE_I,
  output logic [KIND_W-1:0] TRANSFER_KIND_CODE_O,
  input wire logic [SIZE_W-1:0] TRANSFER_BYTE_COUNT_I,
  output logic [SIZE_W-1:0] TRANSFER_BYTE_COUNT_O,
  input wire logic BURST_TRANSFER_FLAG_I,
  output logic BURST_TRANSFER_FLAG_O,
  input wire logic SNOOP_GLOBAL_FLAG_I,
  output logic SNOOP_GLOBAL_FLAG_O,
  output logic QUAL_OE_N,
  // External start seen from another master.
  input wire logic EXT_START,
  // Sampled external tenure toward the device.
  output logic EXT_VALID,
  output logic [ADDR_W-1:0] EXT_ADDR,
  output logic [KIND_W-1:0] EXT_KIND,
  output logic [SIZE_W-1:0] EXT_SIZE,
  output logic EXT_BURST,
  output logic EXT_GLOBAL,
  // Burst address outputs; bits 29-31 are shared pins.
  output logic [1:0] BURST_ADDR_LOW,
  output logic BURST_ADDR_BIT_29,
  output logic BURST_ADDR_BIT_30,
  output logic BURST_ADDR_BIT_31,
  output logic [SHARED_N-1:0] SHARED_OE_N,
  input wire logic INTERRUPT_REQUEST_TWO,
  input wire logic INTERRUPT_REQUEST_THREE,
  input wire logic INTERRUPT_REQUEST_FIVE,
  // Dedicated interrupt pins, active high.
  input wire logic [IRQ_N-1:0] IRQ_DEDICATED,
  // Internal interrupt requests to the core.
  output logic [IRQ_N-1:0] IRQ_CORE
);

  ////////////////////////////////////////////////////////////////////////////
  // Configuration.
  logic [SHARED_N-1:0] pin_sel_reg;
  logic [IRQ_N-1:0] alt_route_reg;
  // The default routing gives doubled lines for interrupt one and seven.
  localparam logic [IRQ_N-1:0] ALT_ROUTE_RST =
    IRQ_N'((1 << IRQ_IDX_ONE) | (1 << IRQ_IDX_SEVEN));

  // Pin selection resets to interrupt input on all shared pins.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_sel_reg <= PIN_SEL_RST; // RULE12
    end else if (PIN_SEL_WR) begin
      pin_sel_reg <= PIN_SEL_WR_DATA; // RULE12
    end
  end

  // Software drops the duplicate copies once it has picked one line each.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      alt_route_reg <= ALT_ROUTE_RST; // RULE1
    end else if (ALT_ROUTE_WR) begin
      alt_route_reg <= ALT_ROUTE_WR_DATA; // RULE2
    end
  end

  assign PIN_SEL = pin_sel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address tenure state machine.
  sbsi_state_e state_reg;
  sbsi_state_e state_next;

  // True on the edge at which an idle bus enters the given tenure.
  function automatic logic tenure_taken(input sbsi_state_e cur, input sbsi_state_e nxt,
                                        input sbsi_state_e goal);
    return (cur == SBSI_IDLE) && (nxt == goal);
  endfunction : tenure_taken

  // Own tenure holds until address acknowledge; external tenure likewise.
  always_comb begin
    case (state_reg)
      SBSI_IDLE: begin
        if (EXT_MASTER_MODE && INT_START) begin
          state_next = SBSI_OWN;
        end else if (EXT_MASTER_MODE && EXT_START) begin
          state_next = SBSI_EXT;
        end else begin
          state_next = SBSI_IDLE;
        end
      end
      SBSI_OWN: begin
        state_next = ADDR_ACK ? SBSI_IDLE : SBSI_OWN; // RULE6
      end
      SBSI_EXT: begin
        state_next = ADDR_ACK ? SBSI_IDLE : SBSI_EXT;
      end
      default: begin
        state_next = SBSI_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= SBSI_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign INT_BUSY = (state_reg == SBSI_OWN);

  ////////////////////////////////////////////////////////////////////////////
  // Driven address and qualifiers, captured at start and held to the end.
  logic [ADDR_W-1:0] addr_reg;
  logic [KIND_W-1:0] kind_reg;
  logic [SIZE_W-1:0] size_reg;
  logic burst_reg;
  logic global_reg;
  logic own_oe_n_reg;

  // Capture on start so pins stay stable even if the master changes inputs.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_reg <= '0;
      kind_reg <= '0;
      size_reg <= '0;
      burst_reg <= 1'b0;
      global_reg <= 1'b0;
    end else if (tenure_taken(state_reg, state_next, SBSI_OWN)) begin
      addr_reg <= INT_ADDR; // RULE4
      kind_reg <= INT_KIND; // RULE6
      size_reg <= INT_SIZE; // RULE7
      burst_reg <= INT_BURST; // RULE8
      global_reg <= INT_GLOBAL; // RULE9
    end
  end

  // Qualifier pins, and address pins in external master mode, are driven only while the device owns the address tenure.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      own_oe_n_reg <= 1'b1;
    end else begin
      own_oe_n_reg <= !(state_next == SBSI_OWN); // RULE6
    end
  end

  // In internal master mode the memory controller owns the address pins.
  assign ADDR_O = EXT_MASTER_MODE ? addr_reg : MC_ADDR; // RULE4 RULE5
  assign ADDR_OE_N = EXT_MASTER_MODE ? own_oe_n_reg : 1'b0; // RULE5
  assign TRANSFER_KIND_CODE_O = kind_reg;
  assign TRANSFER_BYTE_COUNT_O = size_reg;
  assign BURST_TRANSFER_FLAG_O = burst_reg;
  assign SNOOP_GLOBAL_FLAG_O = global_reg;
  assign QUAL_OE_N = own_oe_n_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Sampling of an external master's tenure.
  logic ext_valid_reg;
  logic [ADDR_W-1:0] ext_addr_reg;
  logic [KIND_W-1:0] ext_kind_reg;
  logic [SIZE_W-1:0] ext_size_reg;
  logic ext_burst_reg;
  logic ext_global_reg;

  // One-cycle pulse with the captured qualifiers when an idle bus in external master mode takes an external start.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_valid_reg <= 1'b0;
      ext_addr_reg <= '0;
      ext_kind_reg <= '0;
      ext_size_reg <= '0;
      ext_burst_reg <= 1'b0;
      ext_global_reg <= 1'b0;
    end else begin
      ext_valid_reg <= tenure_taken(state_reg, state_next, SBSI_EXT); // RULE4
      if (tenure_taken(state_reg, state_next, SBSI_EXT)) begin
        ext_addr_reg <= ADDR_I; // RULE4
        ext_kind_reg <= TRANSFER_KIND_CODE_I;
        ext_size_reg <= TRANSFER_BYTE_COUNT_I;
        ext_burst_reg <= BURST_TRANSFER_FLAG_I;
        ext_global_reg <= SNOOP_GLOBAL_FLAG_I; // RULE9
      end
    end
  end

  assign EXT_VALID = ext_valid_reg;
  assign EXT_ADDR = ext_addr_reg;
  assign EXT_KIND = ext_kind_reg;
  assign EXT_SIZE = ext_size_reg;
  assign EXT_BURST = ext_burst_reg;
  assign EXT_GLOBAL = ext_global_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Burst address outputs and shared pins; no reserved primary function exists.
  logic [BADDR_W-1:0] baddr_reg;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      baddr_reg <= '0;
    end else begin
      baddr_reg <= MC_BADDR; // RULE10
    end
  end

  assign BURST_ADDR_LOW = baddr_reg[1:0];
  assign BURST_ADDR_BIT_29 = baddr_reg[BADDR_IDX_29]; // RULE10
  assign BURST_ADDR_BIT_30 = baddr_reg[BADDR_IDX_30];
  assign BURST_ADDR_BIT_31 = baddr_reg[BADDR_IDX_31];
  // Driver is off while the pin serves as an interrupt input.
  assign SHARED_OE_N = pin_sel_reg; // RULE11 RULE12

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt routing.
  sbsi_irq_route u_irq_route (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .irq_dedicated(IRQ_DEDICATED),
    .irq_shared({INTERRUPT_REQUEST_FIVE, INTERRUPT_REQUEST_THREE, INTERRUPT_REQUEST_TWO}),
    .pin_sel(pin_sel_reg),
    .alt_route(alt_route_reg),
    .irq_core(IRQ_CORE)
  );
endmodule : sbsi_top

// file: rtl/sbsi_pkg.sv
// Package of constants and types for the system bus signal interface.
package sbsi_pkg;
  // Address bus width.
  localparam int ADDR_W = 32;
  // Transfer kind code width.
  localparam int KIND_W = 5;
  // Transfer byte count code width.
  localparam int SIZE_W = 4;
  // Number of burst address outputs of the memory controller.
  localparam int BADDR_W = 5;
  // Number of internal interrupt request inputs to the core.
  localparam int IRQ_N = 8;
  // Number of shared pins (burst address bit 29, 30, 31).
  localparam int SHARED_N = 3;
  // Index of the shared pins within the burst address outputs.
  localparam int BADDR_IDX_29 = 2;
  localparam int BADDR_IDX_30 = 3;
  localparam int BADDR_IDX_31 = 4;
  // Internal interrupt numbers served by the shared pins and by the alternate routing.
  localparam int IRQ_IDX_ONE = 1;
  localparam int IRQ_IDX_TWO = 2;
  localparam int IRQ_IDX_THREE = 3;
  localparam int IRQ_IDX_FIVE = 5;
  localparam int IRQ_IDX_SEVEN = 7;
  // Per-pin selection: 1 means interrupt input, 0 burst address output.
  localparam logic [SHARED_N-1:0] PIN_SEL_RST = 3'h7;
  // Tenure state machine, Gray coded: idle to either tenure and back flips one bit.
  typedef enum logic [1:0] {
    SBSI_IDLE = 2'h0,
    SBSI_OWN = 2'h1,
    SBSI_EXT = 2'h2
  } sbsi_state_e;
endpackage : sbsi_pkg

// file: rtl/sbsi_irq_route.sv
// Interrupt routing of dedicated and shared pins onto internal requests.
`timescale 1ns/1ns
module sbsi_irq_route
  import sbsi_pkg::*;
(
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pin levels, active high as taken from the pins.
  input wire logic [IRQ_N-1:0] irq_dedicated,
  input wire logic [SHARED_N-1:0] irq_shared,
  input wire logic [SHARED_N-1:0] pin_sel,
  input wire logic [IRQ_N-1:0] alt_route,
  // Routed internal requests.
  output logic [IRQ_N-1:0] irq_core
);
  logic [IRQ_N-1:0] irq_reg;
  logic [IRQ_N-1:0] irq_next;

  // A shared pin contributes only while selected as interrupt input.
  always_comb begin
    irq_next = irq_dedicated;
    if (pin_sel[0]) begin
      irq_next[IRQ_IDX_TWO] = irq_next[IRQ_IDX_TWO] | irq_shared[0]; // RULE3
    end
    if (pin_sel[1]) begin
      irq_next[IRQ_IDX_THREE] = irq_next[IRQ_IDX_THREE] | irq_shared[1]; // RULE3
    end
    if (pin_sel[2]) begin
      irq_next[IRQ_IDX_FIVE] = irq_next[IRQ_IDX_FIVE] | irq_shared[2]; // RULE3
    end
    // Alternate copies of request one and seven, on by default.
    irq_next[IRQ_IDX_ONE] = irq_next[IRQ_IDX_ONE] | alt_route[IRQ_IDX_ONE]; // RULE1
    irq_next[IRQ_IDX_SEVEN] = irq_next[IRQ_IDX_SEVEN] | alt_route[IRQ_IDX_SEVEN]; // RULE1
  end

  // Registered so the core sees a clean level each cycle.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= irq_next;
    end
  end

  assign irq_core = irq_reg;
endmodule : sbsi_irq_route

// file: dv/sbsi_checker.sv
// Port assertions of the system bus signal interface.
`timescale 1ns/1ns
module sbsi_checker
  import sbsi_pkg::*;
(
  // Clock, reset and mode.
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic EXT_MASTER_MODE,
  // Pin select.
  input wire logic PIN_SEL_WR,
  input wire logic [SHARED_N-1:0] PIN_SEL_WR_DATA,
  input wire logic [SHARED_N-1:0] SHARED_OE_N,
  // Tenures and pins.
  input wire logic INT_START,
  input wire logic [KIND_W-1:0] INT_KIND,
  input wire logic ADDR_ACK,
  input wire logic INT_BUSY,
  input wire logic EXT_START,
  input wire logic EXT_VALID,
  input wire logic ADDR_OE_N,
  input wire logic QUAL_OE_N,
  input wire logic [KIND_W-1:0] TRANSFER_KIND_CODE_O,
  input wire logic [ADDR_W-1:0] MC_ADDR,
  input wire logic [ADDR_W-1:0] ADDR_O,
  // Burst address and interrupts.
  input wire logic [BADDR_W-1:0] MC_BADDR,
  input wire logic BURST_ADDR_BIT_31,
  input wire logic [IRQ_N-1:0] IRQ_DEDICATED,
  input wire logic [IRQ_N-1:0] IRQ_CORE
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  ////////////////////////////////////////
  // An external tenure lasts from its capture to the acknowledge; starts are ignored then.
  logic ext_act_reg;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ext_act_reg <= 1'b0;
    end else begin
      ext_act_reg <= EXT_VALID | (ext_act_reg & ~ADDR_ACK);
    end
  end
  // The bus is free for a new tenure.
  sequence s_idle;
    EXT_MASTER_MODE && !INT_BUSY && !EXT_VALID && !ext_act_reg;
  endsequence
  sequence s_own_take;
    s_idle ##0 INT_START;
  endsequence
  ////////////////////////////////////////
  AST_PIN_SEL: assert property (PIN_SEL_WR |=> SHARED_OE_N == $past(PIN_SEL_WR_DATA))
    else $error("shared pin select not applied");
  AST_OWN: assert property (s_own_take |=> INT_BUSY && !ADDR_OE_N && !QUAL_OE_N
    && TRANSFER_KIND_CODE_O == $past(INT_KIND)) else $error("own tenure not started");
  AST_HOLD: assert property (INT_BUSY && !ADDR_ACK |=> INT_BUSY && $stable(ADDR_O)
    && $stable(TRANSFER_KIND_CODE_O)) else $error("tenure pins changed");
  AST_END: assert property (INT_BUSY && ADDR_ACK |=> !INT_BUSY && ADDR_OE_N && QUAL_OE_N)
    else $error("tenure not released");
  AST_MEM: assert property (!EXT_MASTER_MODE && !$past(EXT_MASTER_MODE)
    |-> ADDR_O == MC_ADDR && !ADDR_OE_N) else $error("memory address not on pins");
  AST_EXT: assert property (s_idle ##0 EXT_START && !INT_START |=> EXT_VALID)
    else $error("external tenure not captured");
  AST_BADDR: assert property (1'b1 |=> BURST_ADDR_BIT_31 == $past(MC_BADDR[BADDR_IDX_31]))
    else $error("burst address bit wrong");
  AST_IRQ: assert property (1'b1 |=> IRQ_CORE[6] == $past(IRQ_DEDICATED[6]))
    else $error("dedicated request not routed");
endmodule : sbsi_checker
bind sbsi_top sbsi_checker u_chk (.*);

// file: dv/sbsi_bus_partner.sv
// Behavioural external master and address slave on the system bus.
`timescale 1ns/1ns
module sbsi_bus_partner (
  // Clock and bench commands.
  input wire logic clk,
  input wire logic go,
  input wire logic [31:0] addr,
  input wire logic [7:0] dly,
  // Bus side.
  input wire logic busy,
  output logic start = 1'b0,
  output logic [31:0] addr_pins = 32'h0,
  output logic [10:0] q = 11'h0,
  output logic ack = 1'b0
);
  logic [7:0] cnt = 8'h00;
  logic own = 1'b0;
  // Released pins show the inverse of the last value, so stale data never looks valid.
  always @(posedge clk) begin
    start <= go;
    addr_pins <= go ? addr : ~addr_pins;
    q <= go ? addr[10:0] : ~q;
    ack <= 1'b0;
    if (go) begin
      own <= 1'b1;
    end
    if ((busy || own) && !ack) begin
      cnt <= cnt + 8'h01;
      if (cnt == dly) begin
        ack <= 1'b1;
        cnt <= 8'h00;
        own <= 1'b0;
      end
    end
  end
endmodule : sbsi_bus_partner

// file: dv/sbsi_top_tb.sv
// Self-checking testbench of the system bus signal interface.
`timescale 1ns/1ns
module sbsi_top_tb;
  // Stimulus, given values at time zero.
  logic CORE_CLK = 1'b0, RST_N = 1'b0, EXT_MASTER_MODE = 1'b1, go = 1'b0;
  logic PIN_SEL_WR = 1'b0, ALT_ROUTE_WR = 1'b0, INT_START = 1'b0, INT_BURST = 1'b0;
  logic INT_GLOBAL = 1'b0, INTERRUPT_REQUEST_TWO = 1'b0, INTERRUPT_REQUEST_THREE = 1'b0;
  logic INTERRUPT_REQUEST_FIVE = 1'b0;
  logic [2:0] PIN_SEL_WR_DATA = 3'h7;
  logic [7:0] ALT_ROUTE_WR_DATA = 8'h82, IRQ_DEDICATED = 8'h00, ack_dly = 8'h00;
  logic [4:0] INT_KIND = 5'h00, MC_BADDR = 5'h00;
  logic [3:0] INT_SIZE = 4'h0;
  logic [31:0] INT_ADDR = 32'h0, MC_ADDR = 32'h0, go_addr = 32'h0;
  // Outputs and partner pins.
  logic ADDR_ACK, INT_BUSY, ADDR_OE_N, QUAL_OE_N, EXT_START, EXT_VALID, EXT_BURST, EXT_GLOBAL;
  logic BURST_TRANSFER_FLAG_I, BURST_TRANSFER_FLAG_O, SNOOP_GLOBAL_FLAG_I, SNOOP_GLOBAL_FLAG_O;
  logic BURST_ADDR_BIT_29, BURST_ADDR_BIT_30, BURST_ADDR_BIT_31;
  logic [1:0] BURST_ADDR_LOW;
  logic [2:0] PIN_SEL, SHARED_OE_N;
  logic [3:0] TRANSFER_BYTE_COUNT_I, TRANSFER_BYTE_COUNT_O, EXT_SIZE;
  logic [4:0] TRANSFER_KIND_CODE_I, TRANSFER_KIND_CODE_O, EXT_KIND;
  logic [7:0] IRQ_CORE;
  logic [31:0] ADDR_I, ADDR_O, EXT_ADDR;
  int num_errors = 0, total_checks = 0, cycles = 0;
  sbsi_bus_partner partner (.clk(CORE_CLK), .go(go), .addr(go_addr), .dly(ack_dly),
    .busy(INT_BUSY), .start(EXT_START), .addr_pins(ADDR_I), .ack(ADDR_ACK),
    .q({SNOOP_GLOBAL_FLAG_I, BURST_TRANSFER_FLAG_I, TRANSFER_BYTE_COUNT_I, TRANSFER_KIND_CODE_I}));
  sbsi_top uut (.*);
  ////////////////////////////////////////
  // Clock; the cycle ceiling cuts a hang short.
  always #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Requests read clear on the release edge; the alternate copies show one edge later.
  task automatic t_reset;
    @(negedge CORE_CLK);
    chk(IRQ_CORE, 8'h00);
    @(posedge CORE_CLK);
    @(negedge CORE_CLK);
    chk(IRQ_CORE, 8'h82);
    chk({PIN_SEL, SHARED_OE_N}, 6'h3f);
  endtask : t_reset
  // Duplicates moved away, then each line reaches its own request only.
  task automatic t_route;
    @(posedge CORE_CLK);
    ALT_ROUTE_WR_DATA <= 8'h00;
    ALT_ROUTE_WR <= 1'b1;
    @(posedge CORE_CLK);
    ALT_ROUTE_WR <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      @(posedge CORE_CLK);
      IRQ_DEDICATED <= 8'h01 << i;
      repeat (2) @(negedge CORE_CLK);
      chk(IRQ_CORE, 8'h01 << i);
    end
  endtask : t_route
  // Shared pins as requests, then switched to burst address outputs.
  task automatic t_shared;
    @(posedge CORE_CLK);
    IRQ_DEDICATED <= 8'h00;
    INTERRUPT_REQUEST_TWO <= 1'b1;
    INTERRUPT_REQUEST_THREE <= 1'b1;
    INTERRUPT_REQUEST_FIVE <= 1'b1;
    MC_BADDR <= 5'h15;
    repeat (2) @(negedge CORE_CLK);
    chk(IRQ_CORE, 8'h2c);
    @(posedge CORE_CLK);
    PIN_SEL_WR_DATA <= 3'h0;
    PIN_SEL_WR <= 1'b1;
    @(posedge CORE_CLK);
    PIN_SEL_WR <= 1'b0;
    repeat (2) @(negedge CORE_CLK);
    chk(IRQ_CORE, 8'h00);
    chk(PIN_SEL, 3'h0);
    chk({SHARED_OE_N, BURST_ADDR_BIT_31, BURST_ADDR_BIT_30, BURST_ADDR_BIT_29,
      BURST_ADDR_LOW}, 8'h15);
  endtask : t_shared
  // Own tenure; qualifiers stay on the pins until the slave acknowledges.
  task automatic t_own(input logic [31:0] a, input logic [10:0] q, input logic [7:0] d);
    @(posedge CORE_CLK);
    ack_dly <= d;
    INT_START <= 1'b1;
    INT_ADDR <= a;
    {INT_GLOBAL, INT_BURST, INT_SIZE, INT_KIND} <= q;
    @(posedge CORE_CLK);
    INT_START <= 1'b0;
    @(negedge CORE_CLK);
    chk({ADDR_OE_N, QUAL_OE_N, INT_BUSY}, 3'h1);
    chk(ADDR_O, a);
    chk({SNOOP_GLOBAL_FLAG_O, BURST_TRANSFER_FLAG_O, TRANSFER_BYTE_COUNT_O,
      TRANSFER_KIND_CODE_O}, q);
    for (int i = 0; i < 40 && INT_BUSY === 1'b1; i++) @(negedge CORE_CLK);
    chk({ADDR_OE_N, QUAL_OE_N, INT_BUSY}, 3'h6);
  endtask : t_own
  // Tenure of another master is captured and answered.
  task automatic t_ext(input logic [31:0] a);
    @(posedge CORE_CLK);
    ack_dly <= 8'd2;
    go_addr <= a;
    go <= 1'b1;
    @(posedge CORE_CLK);
    go <= 1'b0;
    for (int i = 0; i < 10 && EXT_VALID !== 1'b1; i++) @(negedge CORE_CLK);
    chk(EXT_VALID, 1'b1);
    chk(EXT_ADDR, a);
    chk({EXT_GLOBAL, EXT_BURST, EXT_SIZE, EXT_KIND}, a[10:0]);
    for (int i = 0; i < 10 && ADDR_ACK !== 1'b1; i++) @(negedge CORE_CLK);
    @(negedge CORE_CLK);
  endtask : t_ext
  // Internal master mode: memory controller owns the pins, starts are refused.
  task automatic t_mem;
    @(posedge CORE_CLK);
    EXT_MASTER_MODE <= 1'b0;
    MC_ADDR <= 32'hcafe0010;
    INT_START <= 1'b1;
    @(posedge CORE_CLK);
    INT_START <= 1'b0;
    repeat (2) @(negedge CORE_CLK);
    chk(ADDR_O, 32'hcafe0010);
    chk({ADDR_OE_N, INT_BUSY}, 2'h0);
  endtask : t_mem
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // Main sequence.
  initial begin
    repeat (20) @(posedge CORE_CLK);
    RST_N <= 1'b1;
    t_reset();
    t_route();
    t_shared();
    t_own(32'h80000004, 11'h4a3, 8'd0);
    t_own(32'h12345678, 11'h3f1, 8'd5);
    t_ext(32'h0f0f07b6);
    t_mem();
    report_and_stop();
  end
endmodule : sbsi_top_tb
